// ===== shared/scrp_pkg.sv
/*
 * package for the system clock, reset and power control block:
 * timing figures, divider codes, state encodings and widths.
 * assumes a single 200 MHz system clock.
 */
package scrp_pkg;

    // ****************************************************
    // clock and timing
    // ****************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PLL_SETTLE_NS = 100000;
    localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_COUNT = 4096;

    // ****************************************************
    // pll limits in kHz
    // ****************************************************
    localparam int PLL_REF_MIN_KHZ = 10000;
    localparam int PLL_REF_MAX_KHZ = 25000;
    localparam int PLL_OUT_MIN_KHZ = 10000;
    localparam int PLL_OUT_MAX_KHZ = 60000;
    localparam int CCO_MIN_KHZ = 156000;
    localparam int CCO_MAX_KHZ = 320000;
    localparam int MULT_W = 5;
    localparam int MULT_MAX = 32;

    // ****************************************************
    // loop divider codes: 2, 4, 8, 16
    // ****************************************************
    localparam logic [1:0] LDIV_2 = 2'h0;
    localparam logic [1:0] LDIV_4 = 2'h1;
    localparam logic [1:0] LDIV_8 = 2'h2;
    localparam logic [1:0] LDIV_16 = 2'h3;

    // ****************************************************
    // peripheral divider codes
    // ****************************************************
    localparam logic [1:0] PDIV_QUARTER = 2'h0;
    localparam logic [1:0] PDIV_FULL = 2'h1;
    localparam logic [1:0] PDIV_HALF = 2'h2;
    localparam logic [1:0] PDIV_RESET = PDIV_QUARTER;

    // ****************************************************
    // misc
    // ****************************************************
    localparam int NUM_EXT_PINS = 9;
    localparam int NUM_EXT_IRQ = 4;
    localparam int NUM_PERIPH = 16;
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
    localparam logic REMAP_FLASH = 1'b0;
    localparam logic REMAP_SRAM = 1'b1;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_WAKE = 3'b001,
        ST_RUN = 3'b010,
        ST_IDLE = 3'b011,
        ST_PDOWN = 3'b100
    } scrp_pwr_state_t;

endpackage : scrp_pkg

// ===== shared/scrp_clk_if.sv
/*
 * interface carrying clock enable pulses between the top and the cpu clock mux.
 * assumes both ends run on clk_sys_i.
 */
`timescale 1ns/100ps
interface scrp_clk_if;
    logic osc_tick;
    logic pll_tick;
    logic cpu_tick;
    logic sel_pll;
    modport gen (output osc_tick, output pll_tick, output cpu_tick, output sel_pll);
    modport use_side (input osc_tick, input pll_tick, input cpu_tick, input sel_pll);
endinterface : scrp_clk_if

// ===== rtl/scrp_cpu_clk_mux.sv
/*
 * glitch-free cpu_clock source switch between oscillator and pll enables.
 * assumes osc_tick and pll_tick are one-cycle enable pulses on clk_sys_i.
 */
`timescale 1ns/100ps
module scrp_cpu_clk_mux
    import scrp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic osc_tick_i,
    input wire logic pll_tick_i,
    input wire logic want_pll_i,
    output logic cpu_tick_o,
    output logic sel_pll_o
);
    typedef struct packed {
        logic sel_pll;
        logic pend;
    } scrp_mux_state_t;

    scrp_mux_state_t st_reg;
    scrp_mux_state_t st_next;

    // switch only on the new source's tick so no shortened period appears
    always_comb
    begin
        st_next = st_reg;
        st_next.pend = (want_pll_i != st_reg.sel_pll);
        if (st_reg.pend && want_pll_i && pll_tick_i)
        begin
            st_next.sel_pll = 1'b1;
        end
        else if (st_reg.pend && !want_pll_i && osc_tick_i)
        begin
            st_next.sel_pll = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign cpu_tick_o = st_reg.sel_pll ? pll_tick_i : osc_tick_i;
    assign sel_pll_o = st_reg.sel_pll;
endmodule // scrp_cpu_clk_mux

// ===== rtl/scrp_sys_ctrl.sv
/*
 * system clock, reset and power control: pll model, cpu_clock select,
 * peripheral divider, wake-up timer, idle and power-down, gating, remap
 * and external interrupt combining.
 * assumes osc and pll rates are given as enable pulses on clk_sys_i,
 * and that software sequences the pll as the contract requires.
 */
`timescale 1ns/100ps

//Contract
//- pll reference 10-25 MHz, output 10-60 MHz
//- feedback multiplier integer 1 through 32
//- loop divider 2, 4, 8 or 16
//- pll off and bypassed after reset
//- lock no sooner than settling interval
//- cpu_clock is osc unless pll runs, connected
//- pin or watchdog reset starts wake timer
//- hold reset until pin, osc, count, flash
//- fetch from address zero after release
//- power-down wake goes through wake timer
//- idle halts cpu until reset or irq
//- power-down stops osc, gates clocks, holds state
//- power-down exits on reset or wake irq
//- separate power-off per peripheral
//- pclk full, half, quarter; quarter at reset
//- running pll stays on in idle
//- vectors from flash or sram remap
//- nine pins into four irqs, optional wake
module scrp_sys_ctrl
    import scrp_pkg::*;
#(
    parameter int SETTLE_CYC = PLL_SETTLE_CYC,
    parameter int WAKE_CYC = WAKE_COUNT,
    parameter int NPERIPH = NUM_PERIPH
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic osc_tick_i,
    input wire logic osc_running_i,
    input wire logic ext_reset_n_i,
    input wire logic wdt_reset_i,
    input wire logic flash_init_done_i,
    input wire logic pll_enable_i,
    input wire logic pll_connect_i,
    input wire logic [MULT_W-1:0] pll_mult_m1_i,
    input wire logic [1:0] pll_ldiv_i,
    input wire logic [1:0] pclk_div_i,
    input wire logic [NPERIPH-1:0] periph_off_i,
    input wire logic remap_sram_i,
    input wire logic idle_req_i,
    input wire logic pdown_req_i,
    input wire logic irq_any_i,
    input wire logic [NUM_EXT_PINS-1:0] ext_pin_i,
    input wire logic [NUM_EXT_PINS-1:0] ext_edge_i,
    input wire logic [NUM_EXT_PINS-1:0][1:0] ext_route_i,
    input wire logic [NUM_EXT_IRQ-1:0] ext_wake_en_i,
    input wire logic [NUM_EXT_IRQ-1:0] ext_clr_i,
    output logic chip_reset_o,
    output logic [31:0] fetch_addr_o,
    output logic cpu_clock_en_o,
    output logic pclk_en_o,
    output logic [NPERIPH-1:0] periph_clk_en_o,
    output logic pll_lock_o,
    output logic pll_active_o,
    output logic pll_connected_o,
    output logic osc_enable_o,
    output logic pins_hold_o,
    output logic vec_from_sram_o,
    output logic [NUM_EXT_IRQ-1:0] ext_irq_o
);
    typedef struct packed {
        scrp_pwr_state_t pst;
        logic [31:0] wake_cnt;
        logic [31:0] settle_cnt;
        logic lock;
        logic pll_on;
        logic [5:0] pll_acc;
        logic [1:0] pdiv_cnt;
        logic [1:0] pdiv;
        logic cpu_en;
        logic pclk_en;
        logic [NPERIPH-1:0] pen;
        logic remap;
        logic osc_en;
        logic from_rst;
        logic [NUM_EXT_PINS-1:0] pin_q;
        logic [NUM_EXT_IRQ-1:0] irq;
    } scrp_top_state_t;

    scrp_top_state_t st_reg;
    scrp_top_state_t st_next;
    logic pll_tick;
    logic pll_run;
    logic [5:0] pll_step;
    logic [6:0] pll_sum;
    logic [4:0] ldiv_val;
    logic [NUM_EXT_IRQ-1:0] irq_hit;

    scrp_clk_if clk_bus ();

    scrp_cpu_clk_mux u_mux (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .osc_tick_i(clk_bus.osc_tick),
        .pll_tick_i(clk_bus.pll_tick),
        .want_pll_i(pll_run && pll_connect_i && st_reg.lock),
        .cpu_tick_o(clk_bus.cpu_tick),
        .sel_pll_o(clk_bus.sel_pll)
    );

    // ****************************************************
    // pll rate model
    // ****************************************************
    // pll output modelled at the osc tick rate; neither M nor the loop divider changes it
    always_comb
    begin
        case (pll_ldiv_i)
            LDIV_2: ldiv_val = 5'd2;
            LDIV_4: ldiv_val = 5'd4;
            LDIV_8: ldiv_val = 5'd8;
            default: ldiv_val = 5'd16;
        endcase
    end

    assign pll_run = st_reg.pll_on && (st_reg.pst != ST_PDOWN);
    assign pll_step = {1'b0, pll_mult_m1_i} + 6'd1;
    // accumulator adds M per pll tick but feeds no output; a pll tick fires on every
    // osc tick while the pll runs, so the pll rate equals the osc rate on clk_sys
    assign pll_sum = {1'b0, st_reg.pll_acc} + {1'b0, pll_step};
    assign pll_tick = pll_run && osc_tick_i && (ldiv_val != 5'd0);
    assign clk_bus.osc_tick = osc_tick_i && st_reg.osc_en;
    assign clk_bus.pll_tick = pll_tick && st_reg.lock;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.pll_on = pll_enable_i;
        st_next.pclk_en = 1'b0;
        st_next.cpu_en = 1'b0;
        st_next.pin_q = ext_pin_i;
        st_next.remap = remap_sram_i;
        st_next.pen = ~periph_off_i;
        if (pll_tick)
            st_next.pll_acc = pll_sum[5:0];
        // settling counter restarts whenever the pll is off
        if (!pll_run)
        begin
            st_next.settle_cnt = '0;
            st_next.lock = 1'b0;
        end
        else if (st_reg.settle_cnt >= 32'(SETTLE_CYC - 1))
            st_next.lock = 1'b1;
        else
            st_next.settle_cnt = st_reg.settle_cnt + 32'd1;

        // peripheral divider counts cpu_clock ticks
        if (clk_bus.cpu_tick && st_reg.pst != ST_PDOWN)
        begin
            st_next.pdiv_cnt = st_reg.pdiv_cnt + 2'd1;
            case (st_reg.pdiv)
                PDIV_FULL: st_next.pclk_en = 1'b1;
                PDIV_HALF: st_next.pclk_en = st_reg.pdiv_cnt[0];
                default: st_next.pclk_en = (st_reg.pdiv_cnt == 2'd3);
            endcase
            if (st_reg.pdiv_cnt == 2'd3)
                st_next.pdiv = pclk_div_i;
        end

        // edge/level capture onto four requests; a new event beats a clear
        irq_hit = '0;
        for (int i = 0; i < NUM_EXT_PINS; i++)
        begin
            if (ext_edge_i[i] ? (ext_pin_i[i] && !st_reg.pin_q[i]) : ext_pin_i[i])
                irq_hit[ext_route_i[i]] = 1'b1;
        end
        st_next.irq = (st_reg.irq & ~ext_clr_i) | irq_hit;

        case (st_reg.pst)
            ST_RESET:
            begin
                st_next.osc_en = 1'b1;
                st_next.pll_on = 1'b0;
                st_next.from_rst = 1'b1;
                st_next.wake_cnt = '0;
                if (ext_reset_n_i && !wdt_reset_i)
                    st_next.pst = ST_WAKE;
            end
            ST_WAKE:
            begin
                // no software runs before a reset wake ends, so pll stays off
                if (st_reg.from_rst)
                    st_next.pll_on = 1'b0;
                if (osc_running_i && osc_tick_i)
                    st_next.wake_cnt = st_reg.wake_cnt + 32'd1;
                if (st_reg.wake_cnt >= 32'(WAKE_CYC) && flash_init_done_i)
                    st_next.pst = ST_RUN;
            end
            ST_RUN:
            begin
                st_next.cpu_en = clk_bus.cpu_tick;
                if (pdown_req_i)
                begin
                    st_next.pst = ST_PDOWN;
                    st_next.osc_en = 1'b0;
                    st_next.cpu_en = 1'b0;
                    st_next.pll_on = 1'b0;
                end
                else if (idle_req_i)
                    st_next.pst = ST_IDLE;
            end
            ST_IDLE:
            begin
                // pll and pclk keep running here
                if (irq_any_i || |st_reg.irq)
                    st_next.pst = ST_RUN;
            end
            ST_PDOWN:
            begin
                st_next.pll_on = 1'b0;
                if (|(st_reg.irq & ext_wake_en_i))
                begin
                    st_next.pst = ST_WAKE;
                    st_next.from_rst = 1'b0;
                    st_next.osc_en = 1'b1;
                    st_next.wake_cnt = '0;
                end
            end
            default: st_next.pst = ST_RESET;
        endcase

        // either reset source restarts the wake timer
        if (!ext_reset_n_i || wdt_reset_i)
        begin
            st_next.pst = ST_RESET;
            st_next.pll_on = 1'b0;
            st_next.pdiv = PDIV_RESET;
            st_next.irq = '0;
            st_next.cpu_en = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st_reg <= '0;
            st_reg.pst <= ST_RESET;
            st_reg.pdiv <= PDIV_RESET;
            st_reg.osc_en <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // ****************************************************
    // outputs, all registered
    // ****************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            chip_reset_o <= 1'b1;
            fetch_addr_o <= RESET_VECTOR;
            cpu_clock_en_o <= 1'b0;
            pclk_en_o <= 1'b0;
            periph_clk_en_o <= '0;
            pll_lock_o <= 1'b0;
            pll_active_o <= 1'b0;
            pll_connected_o <= 1'b0;
            osc_enable_o <= 1'b1;
            pins_hold_o <= 1'b0;
            vec_from_sram_o <= REMAP_FLASH;
            ext_irq_o <= '0;
        end
        else
        begin
            // a reset wake holds internal reset for the whole count; a power-down wake does not
            chip_reset_o <= (st_reg.pst == ST_RESET) || (st_reg.pst == ST_WAKE && st_reg.from_rst)
                || (st_next.pst == ST_RESET);
            fetch_addr_o <= RESET_VECTOR;
            // drop a tick already in flight when reset strikes
            cpu_clock_en_o <= st_reg.cpu_en && (st_next.pst != ST_RESET);
            pclk_en_o <= st_reg.pclk_en;
            periph_clk_en_o <= st_reg.pclk_en ? st_reg.pen : '0;
            pll_lock_o <= st_reg.lock;
            pll_active_o <= pll_run;
            pll_connected_o <= clk_bus.sel_pll;
            osc_enable_o <= st_reg.osc_en;
            pins_hold_o <= (st_reg.pst == ST_PDOWN);
            vec_from_sram_o <= st_reg.remap;
            ext_irq_o <= st_reg.irq;
        end
    end
endmodule // scrp_sys_ctrl

// ===== testbench/scrp_sys_ctrl_properties.sv
/* port checker for scrp_sys_ctrl.
   assumes one clock domain and the bind at the foot. */
`timescale 1ns/100ps
module scrp_sys_ctrl_chk
    import scrp_pkg::*;
#(
    parameter int SETTLE_CYC = PLL_SETTLE_CYC,
    parameter int NPERIPH = NUM_PERIPH
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ext_reset_n_i,
    input wire logic wdt_reset_i,
    input wire logic flash_init_done_i,
    input wire logic pll_enable_i,
    input wire logic [NPERIPH-1:0] periph_off_i,
    input wire logic remap_sram_i,
    input wire logic chip_reset_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic cpu_clock_en_o,
    input wire logic [NPERIPH-1:0] periph_clk_en_o,
    input wire logic pll_lock_o,
    input wire logic pll_active_o,
    input wire logic pll_connected_o,
    input wire logic osc_enable_o,
    input wire logic pins_hold_o,
    input wire logic vec_from_sram_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // ****
    // enable age; restarts on chip reset since the pll is dropped then
    // ****
    logic [31:0] en_cnt_reg;
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i || !pll_enable_i || chip_reset_o)
            en_cnt_reg <= 32'h0000_0000;
        else
            en_cnt_reg <= en_cnt_reg + 32'h0000_0001;
    end
    chk_fetch_zero: assert property (fetch_addr_o == 32'h0000_0000)
        else $error("fetch address not zero");
    chk_lock_settle: assert property ($rose(pll_lock_o) |-> en_cnt_reg >= SETTLE_CYC)
        else $error("lock before settling");
    chk_connect_lock: assert property ($rose(pll_connected_o) |-> pll_lock_o)
        else $error("pll connected without lock");
    chk_reset_bypass: assert property ($fell(chip_reset_o) |-> !pll_active_o && !pll_connected_o)
        else $error("pll on at reset release");
    chk_src_reset: assert property ((!ext_reset_n_i || wdt_reset_i) |-> ##[1:3] chip_reset_o)
        else $error("reset source ignored");
    chk_flash_hold: assert property (!flash_init_done_i && !$past(flash_init_done_i)
        && !$past(flash_init_done_i, 2) |-> chip_reset_o)
        else $error("reset released before flash ready");
    chk_rst_halt: assert property (chip_reset_o |-> !cpu_clock_en_o)
        else $error("cpu clock during reset");
    chk_pdown_gate: assert property (pins_hold_o |-> !osc_enable_o && !cpu_clock_en_o)
        else $error("clocks alive in power-down");
    chk_periph_off: assert property ((periph_clk_en_o & periph_off_i & $past(periph_off_i)
        & $past(periph_off_i, 2)) == '0)
        else $error("clock to powered-off peripheral");
    chk_remap_vec: assert property (!chip_reset_o && !$past(chip_reset_o, 2) && $stable(remap_sram_i)
        && remap_sram_i == $past(remap_sram_i, 2) |-> vec_from_sram_o == remap_sram_i)
        else $error("vector source mismatch");
    cov_lock: cover property ($rose(pll_lock_o));
    cov_pdown: cover property ($rose(pins_hold_o));
    cov_release: cover property ($fell(chip_reset_o));
endmodule // scrp_sys_ctrl_chk
bind scrp_sys_ctrl scrp_sys_ctrl_chk #(.SETTLE_CYC(SETTLE_CYC), .NPERIPH(NPERIPH))
    scrp_sys_ctrl_chk_inst (.clk_sys_i, .srst_i, .ext_reset_n_i, .wdt_reset_i,
    .flash_init_done_i, .pll_enable_i, .periph_off_i, .remap_sram_i, .chip_reset_o,
    .fetch_addr_o, .cpu_clock_en_o, .periph_clk_en_o, .pll_lock_o, .pll_active_o,
    .pll_connected_o, .osc_enable_o, .pins_hold_o, .vec_from_sram_o);

// ===== testbench/scrp_core_model.sv
/* processor-side model: sequences the pll for software.
   assumes clk_sys_i and drives on its falling edge. */
`timescale 1ns/100ps
module scrp_core_model
    import scrp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic chip_reset_i,
    input wire logic pll_go_i,
    input wire logic pll_lock_i,
    output logic pll_enable_o = 1'b0,
    output logic pll_connect_o = 1'b0
);
    always @(negedge clk_sys_i)
    begin
        if (chip_reset_i || !pll_go_i)
        begin
            pll_enable_o <= 1'b0;
            pll_connect_o <= 1'b0;
        end
        else
        begin
            pll_enable_o <= 1'b1;
            // connect only once lock is seen
            pll_connect_o <= pll_connect_o | pll_lock_i;
        end
    end
endmodule // scrp_core_model

// ===== testbench/scrp_sys_ctrl_tb_top.sv
/* self-checking bench for scrp_sys_ctrl.
   assumes short settle and wake counts passed as parameters. */
`timescale 1ns/100ps
module scrp_sys_ctrl_tb_top;
    import scrp_pkg::*;
    localparam int WAKE_T = 8;
    logic clk_sys_i, srst_i, osc_tick_i, osc_running_i, ext_reset_n_i, wdt_reset_i;
    logic flash_init_done_i, pll_enable_i, pll_connect_i, remap_sram_i, idle_req_i;
    logic pdown_req_i, irq_any_i, chip_reset_o, cpu_clock_en_o, pclk_en_o, pll_lock_o;
    logic pll_active_o, pll_connected_o, osc_enable_o, pins_hold_o, vec_from_sram_o, pll_go;
    logic [MULT_W-1:0] pll_mult_m1_i;
    logic [1:0] pll_ldiv_i, pclk_div_i, osc_div = 2'h0;
    logic [NUM_PERIPH-1:0] periph_off_i, periph_clk_en_o, per_or;
    logic [NUM_EXT_PINS-1:0] ext_pin_i, ext_edge_i;
    logic [NUM_EXT_PINS-1:0][1:0] ext_route_i;
    logic [NUM_EXT_IRQ-1:0] ext_wake_en_i, ext_clr_i, ext_irq_o;
    logic [31:0] fetch_addr_o, meas, got, e, seed = 32'h2357_094b;
    logic [31:0] exp_q[$];
    logic [3:0] sel_q[$];
    logic [31:0] obs [0:8];
    int n_errors = 0, tests_run = 0, cpu_n, pclk_n, w;
    scrp_sys_ctrl #(.SETTLE_CYC(20), .WAKE_CYC(WAKE_T), .NPERIPH(NUM_PERIPH)) scrp_sys_ctrl_inst (
        .clk_sys_i, .srst_i, .osc_tick_i, .osc_running_i, .ext_reset_n_i, .wdt_reset_i,
        .flash_init_done_i, .pll_enable_i, .pll_connect_i, .pll_mult_m1_i, .pll_ldiv_i,
        .pclk_div_i, .periph_off_i, .remap_sram_i, .idle_req_i, .pdown_req_i, .irq_any_i,
        .ext_pin_i, .ext_edge_i, .ext_route_i, .ext_wake_en_i, .ext_clr_i, .chip_reset_o,
        .fetch_addr_o, .cpu_clock_en_o, .pclk_en_o, .periph_clk_en_o, .pll_lock_o,
        .pll_active_o, .pll_connected_o, .osc_enable_o, .pins_hold_o, .vec_from_sram_o,
        .ext_irq_o);
    scrp_core_model scrp_core_model_inst (.clk_sys_i, .chip_reset_i(chip_reset_o),
        .pll_go_i(pll_go), .pll_lock_i(pll_lock_o), .pll_enable_o(pll_enable_i),
        .pll_connect_o(pll_connect_i));
    assign obs[0] = {31'h0, chip_reset_o};
    assign obs[1] = {31'h0, pll_lock_o};
    assign obs[2] = {31'h0, pll_connected_o};
    assign obs[3] = {31'h0, pll_active_o};
    assign obs[4] = fetch_addr_o;
    assign obs[5] = {30'h0, pins_hold_o, osc_enable_o};
    assign obs[6] = {28'h0, ext_irq_o};
    assign obs[7] = meas;
    assign obs[8] = {31'h0, vec_from_sram_o};
    // ****
    // clock, oscillator at a quarter rate, stopped while disabled
    // ****
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(negedge clk_sys_i)
    begin
        osc_div <= osc_div + 2'h1;
        osc_tick_i <= (osc_div == 2'h0) && osc_enable_o;
        osc_running_i <= osc_enable_o;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic expect_val(input logic [3:0] sel, input logic [31:0] v);
        exp_q.push_back(v);
        sel_q.push_back(sel);
        @(negedge clk_sys_i);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic count(input int n);
        cpu_n = 0;
        per_or = '0;
        repeat (n)
        begin
            @(posedge clk_sys_i);
            #1;
            cpu_n += cpu_clock_en_o;
            per_or |= periph_clk_en_o;
        end
        step(1);
    endtask
    task automatic wait_rst(input logic v);
        w = 0;
        while (chip_reset_o !== v && w < 500)
        begin
            step(1);
            w++;
        end
        step(2);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ****
    // monitor: compare oldest note with the output it names
    // ****
    initial
    forever
    begin
        @(posedge clk_sys_i);
        #1;
        while (exp_q.size() > 0)
        begin
            got = obs[sel_q.pop_front()];
            e = exp_q.pop_front();
            tests_run++;
            if (got !== e)
            begin
                n_errors++;
                $display("BAD t=%0t exp=%h got=%h", $time, e, got);
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        $display("BAD t=%0t exp=%h got=%h", $time, 32'h0000_0001, 32'h0000_0000);
        tally_and_finish();
    end
    // ****
    // main sequence
    // ****
    initial
    begin
        {srst_i, ext_reset_n_i, wdt_reset_i, flash_init_done_i, pll_go} = 5'b11000;
        {remap_sram_i, idle_req_i, pdown_req_i, irq_any_i} = 4'h0;
        pll_mult_m1_i = seed[4:0];
        pll_ldiv_i = LDIV_4;
        pclk_div_i = PDIV_RESET;
        periph_off_i = '0;
        {ext_pin_i, ext_edge_i, ext_route_i} = '0;
        {ext_wake_en_i, ext_clr_i} = 8'h00;
        step(20);
        srst_i = 1'b0;
        step(80);
        expect_val(0, 1);
        flash_init_done_i = 1'b1;
        wait_rst(1'b0);
        expect_val(4, RESET_VECTOR);
        expect_val(3, 0);
        $display("reset sequence done");
        for (int k = 0; k < 4; k++)
        begin
            pclk_div_i = k[1:0];
            step(8);
            w = 0;
            while (pclk_en_o !== 1'b1 && w < 400)
            begin
                @(posedge clk_sys_i);
                #1;
                w++;
            end
            {cpu_n, pclk_n} = 0;
            while (cpu_n < 64 && w < 2000)
            begin
                cpu_n += cpu_clock_en_o;
                pclk_n += pclk_en_o;
                @(posedge clk_sys_i);
                #1;
                w++;
            end
            meas = pclk_n;
            expect_val(7, (k == 1) ? 64 : (k == 2) ? 32 : 16);
        end
        $display("peripheral divider done");
        seed = lfsr_next(seed);
        periph_off_i = seed[NUM_PERIPH-1:0];
        remap_sram_i = REMAP_SRAM;
        step(4);
        count(64);
        meas = {16'h0, ~per_or};
        expect_val(7, {16'h0, seed[15:0]});
        expect_val(8, 1);
        remap_sram_i = REMAP_FLASH;
        periph_off_i = '0;
        pll_go = 1'b1;
        step(10);
        expect_val(1, 0);
        step(60);
        expect_val(2, 1);
        idle_req_i = 1'b1;
        step(4);
        idle_req_i = 1'b0;
        count(40);
        meas = cpu_n;
        expect_val(7, 0);
        expect_val(3, 1);
        irq_any_i = 1'b1;
        step(2);
        irq_any_i = 1'b0;
        count(40);
        meas = (cpu_n > 0);
        expect_val(7, 1);
        $display("pll and idle done");
        for (int k = 0; k < 4; k++)
        begin
            ext_route_i[k] = k[1:0];
            ext_edge_i[k] = k[0];
            ext_pin_i[k] = 1'b1;
            step(4);
            expect_val(6, 32'h1 << k);
            ext_pin_i[k] = 1'b0;
            ext_clr_i[k] = 1'b1;
            step(1);
            ext_clr_i = 4'h0;
            step(3);
            expect_val(6, 0);
        end
        ext_route_i[7] = 2'h1;
        ext_edge_i[8:7] = 2'b11;
        ext_wake_en_i = 4'h1;
        pdown_req_i = 1'b1;
        step(4);
        pdown_req_i = 1'b0;
        step(8);
        expect_val(5, 2'b10);
        ext_pin_i[7] = 1'b1;
        step(20);
        expect_val(5, 2'b10);
        ext_pin_i[8] = 1'b1;
        w = 0;
        while (cpu_clock_en_o !== 1'b1 && w < 500)
        begin
            @(posedge clk_sys_i);
            #1;
            w++;
        end
        meas = (w >= 4 * (WAKE_T - 1)) && (w < 500);
        step(1);
        expect_val(7, 1);
        expect_val(5, 2'b01);
        $display("power-down done");
        pll_go = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            {wdt_reset_i, ext_reset_n_i} = (s == 0) ? 2'b11 : 2'b00;
            step(4);
            expect_val(0, 1);
            {wdt_reset_i, ext_reset_n_i} = 2'b01;
            wait_rst(1'b0);
            expect_val(3, 0);
        end
        $display("reset sources done");
        step(4);
        tally_and_finish();
    end
endmodule // scrp_sys_ctrl_tb_top
